// file: seb_bus_master.sv
// Behavioural two-wire bus master that drives the serial EEPROM slave.
// Assumes a pull-up on sda outside; the master only pulls low or releases.
`timescale 1ns/10ps

module seb_bus_master (
  // Sampling clock for phase alignment
  input  wire logic clk_i,
  // Resolved data line
  input  wire logic sda_i,
  // Bus drive
  output logic      scl_o,
  output logic      sda_low_o
);
  // Idle bus: clock stands high, data released
  initial
  begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  // Start: data falls while clock high
  task start_cond;
    @(posedge clk_i);
    #2;
    sda_low_o = 1'b0;
    #200;
    scl_o = 1'b1;
    #200;
    sda_low_o = 1'b1;
    #200;
    scl_o = 1'b0;
    #100;
  endtask : start_cond

  // Stop: data rises while clock high
  task stop_cond;
    sda_low_o = 1'b1;
    #100;
    scl_o = 1'b1;
    #200;
    sda_low_o = 1'b0;
    #200;
  endtask : stop_cond

  // Eight bits msb first, data set only while clock low
  // Ninth clock: master pulls low when mack, else releases
  // The master alone makes every clock pulse
  // Sampled late in the high phase, since the slave answers slowly
  task xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
            output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sda_low_o = ~tx[i];
      #100;
      scl_o = 1'b1;
      #200;
      rx[i] = sda_i;
      scl_o = 1'b0;
      #100;
    end
    sda_low_o = mack;
    #100;
    scl_o = 1'b1;
    #200;
    ack = ~sda_i;
    scl_o = 1'b0;
    #100;
  endtask : xfer
endmodule : seb_bus_master

// file: seb_defines.svh
// Constants for the serial EEPROM two-wire bus slave.
// Assumes a single 20 MHz system clock; the bus clock is sampled, not used as a clock.
`ifndef SEB_DEFINES_SVH
`define SEB_DEFINES_SVH

// System clock rate
`define SEB_CLK_HZ              20000000
// Longest programming time, standard and low-voltage parts
`define SEB_WRITE_CYCLE_TIME_MS 10
`define SEB_WRITE_CYCLE_TIME_LV_MS 15
// Standard-part longest time rounds down to whole cycles
`define SEB_WR_CYCLES ((`SEB_WRITE_CYCLE_TIME_MS * `SEB_CLK_HZ) / 1000)
// Array geometry
`define SEB_MEM_BYTES           4096
`define SEB_PAGE_BYTES          32
// Bits per byte on the wire
`define SEB_BYTE_BITS           4'h8
// Idle level of a released line
`define SEB_LINE_IDLE           1'b1

`endif

// file: seb_pkg.sv
// Types for the serial EEPROM two-wire bus slave.
// Used by the design module and imported by the bench; holds no constants of its own.
package seb_pkg;

  // Transaction phase, one-hot
  typedef enum logic [5:0] {
    PH_IDLE = 6'h01,
    PH_DEV  = 6'h02,
    PH_AHI  = 6'h04,
    PH_ALO  = 6'h08,
    PH_WDAT = 6'h10,
    PH_RDAT = 6'h20
  } seb_phase_t;

  // Slave address byte as it arrives, msb first
  typedef struct packed {
    logic [3:0] dev_class;
    logic [2:0] dev_sel;
    logic       read;
  } seb_slave_addr_t;

  // Strap pins after synchronising
  typedef struct packed {
    logic       write_protect;
    logic [2:0] dev_sel;
  } seb_straps_t;

endpackage : seb_pkg

// file: seb_serial_eeprom_slave.sv
// Two-wire bus slave front end and storage of a 4096-byte serial EEPROM.
// Assumes scl and sda arrive asynchronously and are oversampled by clk_i;
// the sda wire is resolved outside from sda_oe_b_o (low = pull low).
`timescale 1ns/10ps
`include "seb_defines.svh"

module seb_serial_eeprom_slave
  import seb_pkg::*;
#(
  parameter int unsigned WR_CYCLES = `SEB_WR_CYCLES,
  parameter logic [3:0]  DEV_CLASS = 4'h5  // Arbitrary class code
)(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // Two-wire bus
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_b_o,
  // Strap pins
  input  wire logic select_pin_bit0_i,
  input  wire logic select_pin_bit1_i,
  input  wire logic select_pin_bit2_i,
  input  wire logic write_protect_i,
  // Status
  output logic      busy_o,
  output logic      standby_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [1:0]        scl_sync_q;    // Bus clock synchroniser
  logic [1:0]        sda_sync_q;    // Bus data synchroniser
  seb_straps_t       strap_m_q;     // Strap first stage
  seb_straps_t       strap_q;       // Strap second stage
  seb_straps_t       strap_raw;     // Strap pins gathered
  logic              scl_prev_q;    // Previous sampled clock
  logic              sda_prev_q;    // Previous sampled data
  logic              scl_s;         // Synchronised clock
  logic              sda_s;         // Synchronised data
  logic              scl_rise;      // Bus clock rising
  logic              scl_fall;      // Bus clock falling
  logic              start_ev;      // Data fell with clock high
  logic              stop_ev;       // Data rose with clock high
  seb_phase_t        phase_q;       // Transaction phase
  logic [3:0]        bitcnt_q;      // Bits clocked in this byte
  logic              in_ack_q;      // Inside the ninth clock
  logic [7:0]        shift_q;       // Received byte
  logic [7:0]        tx_q;          // Byte being sent
  logic              pull_q;        // Pull data line low
  logic              mack_q;        // Ninth-clock level was low
  logic [11:0]       addr_q;        // Word address counter
  logic [6:0]        page_q;        // Page being collected
  logic [31:0]       valid_q;       // Page bytes awaiting program
  logic [7:0]        buf_q [0:`SEB_PAGE_BYTES-1];  // Page latch
  logic [7:0]        mem_q [0:`SEB_MEM_BYTES-1];   // Storage array
  logic              busy_q;        // Programming in progress
  logic [31:0]       busy_cnt_q;    // Programming timer
  seb_slave_addr_t   sa;            // Received byte as address
  logic              addr_match;    // Class and select match
  logic              byte_done;     // Fall after eighth bit
  logic              protect_hit;   // Target is write-protected
  logic              buf_we;        // Store a data byte

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  assign strap_raw = '{write_protect: write_protect_i,
                       dev_sel: {select_pin_bit2_i, select_pin_bit1_i,
                                 select_pin_bit0_i}};

  // Two stages for every pin; lines idle high
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      scl_sync_q <= {2{`SEB_LINE_IDLE}};
      sda_sync_q <= {2{`SEB_LINE_IDLE}};
      strap_m_q  <= '0;
      strap_q    <= '0;
      scl_prev_q <= `SEB_LINE_IDLE;
      sda_prev_q <= `SEB_LINE_IDLE;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      strap_m_q  <= strap_raw;
      strap_q    <= strap_m_q;
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  assign scl_s = scl_sync_q[1];
  assign sda_s = sda_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Bus events

  // Edges of the master's clock; the master alone clocks the bus
  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  // Data moving under a high clock is only ever start or stop
  assign start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_ev  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  assign sa          = seb_slave_addr_t'(shift_q);
  // Respond only to own class and strapped select
  assign addr_match  = (sa.dev_class == DEV_CLASS) &&
                       (sa.dev_sel == strap_q.dev_sel);
  assign byte_done   = scl_fall & ~in_ack_q & (bitcnt_q == `SEB_BYTE_BITS);
  // Upper half locked only while the pin is high
  assign protect_hit = strap_q.write_protect & addr_q[11];
  assign buf_we      = ~busy_q & ~start_ev & ~stop_ev & byte_done &
                       (phase_q == PH_WDAT) & ~protect_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine

  // Busy, start and stop take priority over bit traffic
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      phase_q  <= PH_IDLE;
      bitcnt_q <= 4'h0;
      in_ack_q <= 1'b0;
      shift_q  <= 8'h00;
      tx_q     <= 8'h00;
      pull_q   <= 1'b0;
      mack_q   <= 1'b0;
      addr_q   <= 12'h000;
      page_q   <= 7'h00;
      valid_q  <= 32'h0000_0000;
    end
    else if (busy_q)
    begin
      // Interface off while programming, line left high
      phase_q  <= PH_IDLE;
      pull_q   <= 1'b0;
      in_ack_q <= 1'b0;
    end
    else if (start_ev)
    begin
      // Start (also repeated start) opens a new address byte
      phase_q  <= PH_DEV;
      bitcnt_q <= 4'h0;
      in_ack_q <= 1'b0;
      pull_q   <= 1'b0;
    end
    else if (stop_ev)
    begin
      // Stop ends the transaction; standby follows once any write cycle it starts has ended
      phase_q  <= PH_IDLE;
      in_ack_q <= 1'b0;
      pull_q   <= 1'b0;
    end
    else if (phase_q != PH_IDLE)
    begin
      if (scl_rise)
      begin
        if (bitcnt_q < `SEB_BYTE_BITS)
        begin
          // Data bits, msb first
          shift_q  <= {shift_q[6:0], sda_s};
          bitcnt_q <= bitcnt_q + 4'h1;
        end
        else
        begin
          // Ninth clock: low level means acknowledged
          mack_q <= ~sda_s;
        end
      end
      else if (scl_fall)
      begin
        if (in_ack_q)
        begin
          // End of ninth clock: release and start next byte
          in_ack_q <= 1'b0;
          bitcnt_q <= 4'h0;
          pull_q   <= 1'b0;
          if (phase_q == PH_RDAT)
          begin
            if (mack_q)
            begin
              // Acked: send next byte, msb first
              tx_q   <= mem_q[addr_q];
              pull_q <= ~mem_q[addr_q][7];
              addr_q <= addr_q + 12'h001;
            end
            else
            begin
              // No ack: stop sending, wait for stop
              phase_q <= PH_IDLE;
            end
          end
        end
        else if (bitcnt_q == `SEB_BYTE_BITS)
        begin
          in_ack_q <= 1'b1;
          unique case (phase_q)
            PH_DEV:
            begin
              if (addr_match)
              begin
                pull_q  <= 1'b1;
                // One reads, zero writes
                phase_q <= sa.read ? PH_RDAT : PH_AHI;
              end
              else
              begin
                phase_q <= PH_IDLE;
              end
            end
            PH_AHI:
            begin
              // Only the low nibble counts
              addr_q[11:8] <= shift_q[3:0];
              pull_q       <= 1'b1;
              phase_q      <= PH_ALO;
            end
            PH_ALO:
            begin
              addr_q[7:0] <= shift_q;
              page_q      <= {addr_q[11:8], shift_q[7:5]};
              valid_q     <= 32'h0000_0000;
              pull_q      <= 1'b1;
              phase_q     <= PH_WDAT;
            end
            PH_WDAT:
            begin
              if (protect_hit)
              begin
                // Data refused; no program cycle will follow
                phase_q <= PH_IDLE;
              end
              else
              begin
                valid_q[addr_q[4:0]] <= 1'b1;
                // Low five bits wrap inside the page
                addr_q[4:0] <= addr_q[4:0] + 5'h01;
                pull_q      <= 1'b1;
              end
            end
            PH_RDAT:
            begin
              // Release for the master's acknowledge
              pull_q <= 1'b0;
            end
            default:
            begin
              phase_q <= PH_IDLE;
            end
          endcase
        end
        else if (phase_q == PH_RDAT)
        begin
          // Next read bit goes out while the clock is low
          tx_q   <= {tx_q[6:0], 1'b0};
          pull_q <= ~tx_q[6];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page latch

  // Later bytes at a wrapped address simply overwrite
  always_ff @(posedge clk_i)
  begin
    if (buf_we)
    begin
      buf_q[addr_q[4:0]] <= shift_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write cycle timer

  // Starts only on a stop closing a write that stored data
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      busy_q     <= 1'b0;
      busy_cnt_q <= 32'h0000_0000;
    end
    else if (busy_q)
    begin
      busy_cnt_q <= busy_cnt_q + 32'h0000_0001;
      if (busy_cnt_q == WR_CYCLES - 1)
      begin
        busy_q <= 1'b0;
      end
    end
    else if (stop_ev && (phase_q == PH_WDAT) && (|valid_q))
    begin
      busy_q     <= 1'b1;
      busy_cnt_q <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array programming

  // One page byte per cycle at the start of the write cycle;
  // far shorter than the timer, so it always finishes in time
  always_ff @(posedge clk_i)
  begin
    if (busy_q && (busy_cnt_q < `SEB_PAGE_BYTES) && valid_q[busy_cnt_q[4:0]])
    begin
      mem_q[{page_q, busy_cnt_q[4:0]}] <= buf_q[busy_cnt_q[4:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Open drain: output level is always low, only the enable moves
  assign sda_o      = 1'b0;
  assign sda_oe_b_o = ~pull_q;
  assign busy_o     = busy_q;
  assign standby_o  = (phase_q == PH_IDLE) & ~busy_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_busy_silent: assert property (busy_q |=> !pull_q)
    else $error("line pulled during write cycle");
  a_open_drain: assert property (sda_o == 1'b0)
    else $error("data output not low");
  // The pull only moves on a seen clock fall, never under a high clock
  a_pull_clk_low: assert property ($changed(pull_q) |-> !$past(scl_s))
    else $error("data line moved while clock high");
  a_idle_quiet: assert property (phase_q == PH_IDLE && !start_ev |=> !pull_q)
    else $error("line pulled before start");
  a_stop_idle: assert property (stop_ev && !busy_q |=> phase_q == PH_IDLE)
    else $error("stop did not end transaction");
  a_busy_bound: assert property (busy_q |-> busy_cnt_q < WR_CYCLES)
    else $error("write cycle overran");
  a_busy_hold: assert property ($rose(busy_q) |-> busy_q [*8])
    else $error("write cycle ended early");
  a_prot_nack: assert property (byte_done && phase_q == PH_WDAT && protect_hit
                                && !busy_q && !start_ev && !stop_ev
                                |=> !pull_q && phase_q == PH_IDLE)
    else $error("protected data acknowledged");
  a_class_check: assert property (byte_done && phase_q == PH_DEV && !addr_match
                                  && !busy_q && !start_ev && !stop_ev
                                  |=> !pull_q)
    else $error("foreign address acknowledged");
  a_page_wrap: assert property (buf_we |=> addr_q[11:5] == $past(addr_q[11:5]))
    else $error("page address left page");
  a_addr_high: assert property (byte_done && phase_q == PH_AHI && !busy_q && !start_ev
                                && !stop_ev |=> addr_q[11:8] == $past(shift_q[3:0]))
    else $error("high address nibble wrong");

  c_match: cover property (byte_done && phase_q == PH_DEV && addr_match);
  c_commit: cover property ($rose(busy_q));
  c_read: cover property (phase_q == PH_RDAT && in_ack_q && mack_q);
  c_prot: cover property (byte_done && phase_q == PH_WDAT && protect_hit);

endmodule : seb_serial_eeprom_slave

// file: tb.sv
// Self-checking bench for the serial EEPROM two-wire bus slave.
// Assumes the bus master model and the design files compile first.
`timescale 1ns/10ps

module tb;
  import seb_pkg::*;
  localparam int unsigned WR_CYC = 200;   // Short write cycle, outlasts one probe byte
  localparam logic [3:0]  CLS    = 4'h5;  // Arbitrary class code
  localparam logic [2:0]  SEL    = 3'h5;  // Strapped select
  logic       clk_i, rst_b_i, scl, m_low, sda, sda_o, sda_oe_b, wp, busy, standby;
  logic [2:0] sel;
  logic [7:0] rx;
  logic       ack;
  int         miscompares, n_tests;
  int         busy_run = 0;  // Clocks of the running write cycle
  int         busy_len = 0;  // Clocks of the last finished write cycle

  // Wired-and bus with pull-up
  assign sda = ~(m_low | ~sda_oe_b);

  // Measure each write cycle in clocks
  always @(posedge clk_i)
  begin
    if (busy === 1'b1)
      busy_run <= busy_run + 1;
    else if (busy_run != 0)
    begin
      busy_len <= busy_run;
      busy_run <= 0;
    end
  end

  seb_serial_eeprom_slave #(.WR_CYCLES(WR_CYC), .DEV_CLASS(CLS)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_b_o(sda_oe_b), .select_pin_bit0_i(sel[0]), .select_pin_bit1_i(sel[1]),
    .select_pin_bit2_i(sel[2]), .write_protect_i(wp), .busy_o(busy),
    .standby_o(standby));

  seb_bus_master m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One written byte, ack compared
  task xb(input logic [7:0] tx, input logic exp_ack, input string what);
    m.xfer(tx, 1'b0, rx, ack);
    check(what, ack, exp_ack);
  endtask : xb

  // Start, slave address for write, two word-address bytes
  task set_addr(input logic [7:0] hi, input logic [7:0] lo);
    m.start_cond();
    xb({CLS, SEL, 1'b0}, 1'b1, "slave ack");
    xb(hi, 1'b1, "high addr ack");
    xb(lo, 1'b1, "low addr ack");
  endtask : set_addr

  // Busy must rise, then clear within the write cycle time
  task wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      #2;
      n++;
    end
    check("busy rise", busy, 1'b1);
    n = 0;
    while (busy !== 1'b0 && n < 1000)
    begin
      @(posedge clk_i);
      #2;
      n++;
    end
    check("write time", n <= WR_CYC, 1'b1);
    @(posedge clk_i);
    #2;
    check("write cycle length", 16'(busy_len), 16'(WR_CYC));
  endtask : wait_idle

  // Random read of one byte, master ends with nack
  task rd(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] exp);
    set_addr(hi, lo);
    m.start_cond();
    xb({CLS, SEL, 1'b1}, 1'b1, "read ack");
    m.xfer(8'hff, 1'b0, rx, ack);
    check("read data", rx, exp);
    m.stop_cond();
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_reset;
    check("idle release", sda_oe_b, 1'b1);
    check("open drain level", sda_o, 1'b0);
    check("idle busy", busy, 1'b0);
    check("idle standby", standby, 1'b1);
  endtask : t_reset

  // Byte write, silence while busy, high nibble ignored on read
  task t_byte;
    set_addr(8'h01, 8'h23);
    xb(8'ha5, 1'b1, "data ack");
    m.stop_cond();
    m.start_cond();
    xb({CLS, SEL, 1'b0}, 1'b0, "busy slave nack");
    m.stop_cond();
    wait_idle();
    rd(8'hf1, 8'h23, 8'ha5);
    check("standby after stop", standby, 1'b1);
  endtask : t_byte

  // Every select code and a wrong class; write direction, so the
  // slave never drives a data bit that would block the stop
  task t_select;
    for (int s = 0; s < 8; s++)
    begin
      m.start_cond();
      xb({CLS, s[2:0], 1'b0}, s[2:0] == SEL, "select ack");
      m.stop_cond();
    end
    m.start_cond();
    xb({CLS ^ 4'h3, SEL, 1'b0}, 1'b0, "class nack");
    m.stop_cond();
  endtask : t_select

  // Upper half: writable when open, data refused when protected
  task t_protect;
    wp = 1'b0;
    set_addr(8'h08, 8'h00);
    xb(8'h3c, 1'b1, "open data ack");
    m.stop_cond();
    wait_idle();
    wp = 1'b1;
    set_addr(8'h08, 8'h00);
    xb(8'hc3, 1'b0, "protected nack");
    m.stop_cond();
    repeat (20) @(posedge clk_i);
    #2;
    check("no write cycle", busy, 1'b0);
    rd(8'h08, 8'h00, 8'h3c);
    wp = 1'b0;
  endtask : t_protect

  // 33 bytes into one page: the last wraps onto the first
  task t_page;
    set_addr(8'h00, 8'h40);
    for (int i = 0; i < 33; i++)
      xb(8'h80 + 8'(i), 1'b1, "page ack");
    m.stop_cond();
    wait_idle();
    set_addr(8'h00, 8'h40);
    m.start_cond();
    xb({CLS, SEL, 1'b1}, 1'b1, "read ack");
    m.xfer(8'hff, 1'b1, rx, ack);
    check("wrapped byte", rx, 8'ha0);
    m.xfer(8'hff, 1'b0, rx, ack);
    check("next byte", rx, 8'h81);
    m.stop_cond();
  endtask : t_page

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, the only exit
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // 50 ns clock
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Main sequence
  initial
  begin
    rst_b_i = 1'b0;
    wp = 1'b0;
    sel = SEL;
    miscompares = 0;
    n_tests = 0;
    repeat (8) @(posedge clk_i);
    #2;
    rst_b_i = 1'b1;
    repeat (6) @(posedge clk_i);
    #2;
    t_reset();
    t_byte();
    t_select();
    t_protect();
    t_page();
    print_verdict();
  end

  // Watchdog, far beyond the expected run
  initial
  begin
    #2000000;
    miscompares++;
    print_verdict();
  end
endmodule : tb
